//--- hdl/adcsr_ctrl.sv
`timescale 1ns/1ps
module adcsr_ctrl #(
  parameter int MEM_DEPTH = adcsr_pkg::MEM_DEPTH
) (
  input  wire logic        clk_sys,          // System clock, 200 MHz
  input  wire logic        rstn,             // Async reset, active low
  input  wire logic        clk_link,         // Serial link clock
  // Configuration, system domain
  input  wire logic        scanSelectHi,     // Scan code upper bit
  input  wire logic        scanSelectLo,     // Scan code lower bit
  input  wire logic        channelChoiceBit, // Chosen input
  input  wire logic        singleEndedSelect,// 1 single-ended, 0 differential
  input  wire logic        bipolarSelect,    // 1 bipolar coding
  input  wire logic        clockModeExt,     // 1 serial clock converts
  input  wire logic        sourceChoiceHi,   // Internal reference select
  input  wire logic        pinDriveChoice,   // Reference pin role
  input  wire logic        keepOnChoice,     // Internal reference always on
  // Analog core, system domain
  output logic             convStart,        // Start one conversion, pulse
  output logic             convChannel,      // Input to convert
  output logic             convDiff,         // Differential pairing
  output logic             convExtClock,     // Convert on serial clock
  input  wire logic        convDone,         // Conversion finished, pulse
  input  wire logic [11:0] convRaw,          // Offset-binary raw code
  output logic             analogPowerOn,    // Analog circuits powered
  output logic             refPowerOn,       // Internal reference powered
  output logic             refPinDrive,      // Drive reference pin
  output logic [1:0]       refSource,        // Reference source
  output logic             seqBusy,          // Sequencer running
  output logic             resultsHeld,      // Results kept in memory
  // Link side, link domain
  input  wire logic        linkAddrRead,     // Own address with read, pulse
  input  wire logic        linkByteTaken,    // Byte acknowledged, pulse
  input  wire logic        linkNack,         // Not-acknowledge, pulse
  input  wire logic        linkStopRestart,  // STOP or repeated START, pulse
  output logic [7:0]       linkTxByte,       // Byte to shift out
  output logic             linkTxValid,      // Byte ready
  output logic             linkHoldClock     // Stretch serial clock
);

  localparam int MW = $clog2(MEM_DEPTH);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  adcsr_pkg::adcsr_cfg_t   portCfg;
  adcsr_pkg::adcsr_cfg_t   cfg;
  adcsr_pkg::adcsr_state_t state;
  logic [2:0]              prevRefSel;
  logic [3:0]              convCnt;
  logic [3:0]              convTotal;
  logic                    chan;
  logic                    nextChan;
  logic                    stopReq;
  logic                    refKeep;
  logic [11:0]             coded;
  logic                    running;
  // Crossing
  logic                    wakeTgl;
  logic                    reqTgl;
  logic                    nackTgl;
  logic                    stopTgl;
  logic [3:0]              sysSync;
  logic [3:0]              sysPrev;
  logic                    wakeEvt;
  logic                    reqEvt;
  logic                    nackEvt;
  logic                    stopEvt;
  logic                    ackTgl;
  logic                    holdLvl;
  logic [11:0]             txWord;
  logic [1:0]              linkSync;
  logic                    linkAckPrev;
  // Buffer and memory
  logic                    fifoInValid;
  logic                    fifoInReady;
  logic                    fifoOutValid;
  logic                    fifoOutReady;
  logic [11:0]             fifoOutData;
  logic [11:0]             mem [MEM_DEPTH];
  logic [MW:0]             wrIdx;
  logic [MW:0]             rdIdx;
  logic                    reqPending;
  logic                    serveInt;
  logic                    serveExt;
  // Link
  logic [11:0]             linkWord;
  logic                    linkLoPhase;
  logic                    linkWaiting;

  assign portCfg = '{{scanSelectHi, scanSelectLo}, channelChoiceBit,
                     singleEndedSelect, bipolarSelect, clockModeExt,
                     {sourceChoiceHi, pinDriveChoice, keepOnChoice}};

  // ----------------------------------------------------------------
  // Crossing from the link domain
  // ----------------------------------------------------------------
  adcsr_sync #(.W(4)) u_sysSync (
    .clk  (clk_sys),
    .rstn (rstn),
    .din  ({stopTgl, nackTgl, reqTgl, wakeTgl}),
    .dout (sysSync)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sysPrev <= 4'h0;
    end else begin
      sysPrev <= sysSync;
    end
  end

  assign wakeEvt = sysSync[0] ^ sysPrev[0];
  assign reqEvt  = sysSync[1] ^ sysPrev[1];
  assign nackEvt = sysSync[2] ^ sysPrev[2];
  assign stopEvt = sysSync[3] ^ sysPrev[3];

  // ----------------------------------------------------------------
  // Configuration, frozen while converting
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg <= adcsr_pkg::RST_CFG; // see R08
    end else if (state == adcsr_pkg::S_IDLE || state == adcsr_pkg::S_HOLD) begin
      cfg <= portCfg;
    end
  end

  // ----------------------------------------------------------------
  // Scan planning
  // ----------------------------------------------------------------
  always_comb begin
    case (portCfg.scan)
      adcsr_pkg::SCAN_UP: begin
        convTotal = (portCfg.single && portCfg.chan) ? adcsr_pkg::TWO_COUNT
                                                     : adcsr_pkg::ONE_COUNT; // see R01
      end
      adcsr_pkg::SCAN_REPEAT: begin
        convTotal = adcsr_pkg::REPEAT_COUNT; // see R02
      end
      adcsr_pkg::SCAN_SINGLE: begin
        convTotal = adcsr_pkg::ONE_COUNT; // see R04
      end
      default: begin
        convTotal = adcsr_pkg::ONE_COUNT; // see R18
      end
    endcase
  end

  // Scan-up over two single-ended inputs alternates, all else repeats
  assign nextChan = (cfg.scan == adcsr_pkg::SCAN_UP && cfg.single && cfg.chan)
                    ? ~chan : chan; // see R01 R05
  assign coded = cfg.bipolar ? {~convRaw[11], convRaw[10:0]} : convRaw; // see R15
  assign running = state == adcsr_pkg::S_START || state == adcsr_pkg::S_WAIT;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [3:0] heldTotal;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state     <= adcsr_pkg::S_IDLE;
      convCnt   <= 4'h0;
      heldTotal <= adcsr_pkg::ONE_COUNT;
      chan      <= 1'b0;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      case (state)
        adcsr_pkg::S_IDLE, adcsr_pkg::S_HOLD: begin
          if (wakeEvt) begin
            state     <= adcsr_pkg::S_START; // see R13
            convCnt   <= 4'h0;
            heldTotal <= convTotal;
            chan      <= (portCfg.scan == adcsr_pkg::SCAN_UP && portCfg.single)
                         ? 1'b0 : portCfg.chan; // see R01
          end else if (state == adcsr_pkg::S_HOLD && stopEvt) begin
            state <= adcsr_pkg::S_IDLE; // see R12
          end
        end
        adcsr_pkg::S_START: begin
          if (cfg.extClk && (stopReq || nackEvt || stopEvt)) begin
            state <= adcsr_pkg::S_IDLE; // see R05 R10
          end else if (fifoInReady) begin
            convStart <= 1'b1;
            state     <= adcsr_pkg::S_WAIT;
          end
        end
        adcsr_pkg::S_WAIT: begin
          if (convDone) begin
            chan    <= nextChan;
            convCnt <= convCnt + 4'h1;
            if (cfg.extClk) begin
              state <= (stopReq || nackEvt || stopEvt)
                       ? adcsr_pkg::S_IDLE : adcsr_pkg::S_START; // see R05 R10
            end else if (convCnt + 4'h1 == heldTotal) begin
              state <= adcsr_pkg::S_FLUSH; // see R02
            end else begin
              state <= adcsr_pkg::S_START;
            end
          end
        end
        adcsr_pkg::S_FLUSH: begin
          if (!fifoOutValid) begin
            state <= adcsr_pkg::S_HOLD; // see R11
          end
        end
        default: begin
          state <= adcsr_pkg::S_IDLE;
        end
      endcase
    end
  end

  // End of stream seen mid-conversion, honoured at the next boundary in external-clock mode only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stopReq <= 1'b0;
    end else if (running && (nackEvt || stopEvt)) begin
      stopReq <= 1'b1;
    end else if (state == adcsr_pkg::S_IDLE) begin
      stopReq <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer and memory
  // ----------------------------------------------------------------
  assign fifoInValid  = state == adcsr_pkg::S_WAIT && convDone;
  assign fifoOutReady = cfg.extClk ? reqPending : 1'b1;
  assign serveExt     = cfg.extClk && reqPending && fifoOutValid;
  assign serveInt     = !cfg.extClk && reqPending && state == adcsr_pkg::S_HOLD
                        && wrIdx != '0;

  // Idle flushes leftovers of an ended stream
  adcsr_fifo #(.W(adcsr_pkg::RESULT_W), .DEPTH(adcsr_pkg::FIFO_DEPTH)) u_fifo (
    .clk      (clk_sys),
    .rstn     (rstn),
    .flush    (state == adcsr_pkg::S_IDLE),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (coded),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // Memory contents are left unreset on purpose
  always_ff @(posedge clk_sys) begin
    if (!cfg.extClk && fifoOutValid && wrIdx != (MW+1)'(MEM_DEPTH)) begin
      mem[wrIdx[MW-1:0]] <= fifoOutData; // see R08
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrIdx <= '0;
      rdIdx <= '0;
    end else if (wakeEvt && (state == adcsr_pkg::S_IDLE || state == adcsr_pkg::S_HOLD)) begin
      wrIdx <= '0;
      rdIdx <= '0;
    end else if (state == adcsr_pkg::S_IDLE) begin
      wrIdx <= '0; // see R12
      rdIdx <= '0;
    end else begin
      if (!cfg.extClk && fifoOutValid && wrIdx != (MW+1)'(MEM_DEPTH)) begin
        wrIdx <= wrIdx + 1'b1;
      end
      if (serveInt) begin
        rdIdx <= (rdIdx + 1'b1 == wrIdx) ? '0 : rdIdx + 1'b1; // see R12
      end
    end
  end

  // Request flag: a new request wins over clearing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reqPending <= 1'b0;
    end else if (reqEvt) begin
      reqPending <= 1'b1;
    end else if (serveInt || serveExt || nackEvt || stopEvt) begin
      reqPending <= 1'b0;
    end
  end

  // Word handed to the link, stable until the next request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txWord <= 12'h000;
      ackTgl <= 1'b0;
    end else if (serveInt) begin
      txWord <= mem[rdIdx[MW-1:0]];
      ackTgl <= ~ackTgl;
    end else if (serveExt) begin
      txWord <= fifoOutData;
      ackTgl <= ~ackTgl;
    end
  end

  // ----------------------------------------------------------------
  // Analog and reference control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      analogPowerOn <= 1'b0;
      convChannel   <= adcsr_pkg::RST_CHAN;
      convDiff      <= ~adcsr_pkg::RST_SINGLE;
      convExtClock  <= adcsr_pkg::RST_EXTCLK;
      seqBusy       <= 1'b0;
      resultsHeld   <= 1'b0;
      holdLvl       <= 1'b0;
    end else begin
      analogPowerOn <= running; // see R09 R11
      convChannel   <= chan;
      convDiff      <= ~cfg.single;
      convExtClock  <= cfg.extClk; // see R16
      seqBusy       <= state != adcsr_pkg::S_IDLE && state != adcsr_pkg::S_HOLD;
      resultsHeld   <= state == adcsr_pkg::S_HOLD; // see R12
      holdLvl       <= !cfg.extClk && (running || state == adcsr_pkg::S_FLUSH);
    end
  end

  // Reference stays up once woken, until a different setting arrives
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prevRefSel <= adcsr_pkg::RST_REFSEL;
      refKeep    <= 1'b0;
      refPowerOn <= 1'b0;
      refPinDrive <= 1'b0;
      refSource  <= adcsr_pkg::REF_SRC_SUPPLY;
    end else begin
      prevRefSel <= cfg.refSel;
      if (cfg.refSel != prevRefSel) begin
        refKeep <= 1'b0; // see R07
      end else if (cfg.refSel[2] && running) begin
        refKeep <= 1'b1; // see R07
      end
      refPowerOn  <= cfg.refSel[2] && (cfg.refSel[0] || refKeep || running); // see R06 R09
      refPinDrive <= cfg.refSel[2] && cfg.refSel[1] && running; // see R06
      refSource   <= cfg.refSel[2] ? adcsr_pkg::REF_SRC_INTERNAL
                   : cfg.refSel[1] ? adcsr_pkg::REF_SRC_EXTERNAL
                   : adcsr_pkg::REF_SRC_SUPPLY; // see R06
    end
  end

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  adcsr_sync #(.W(2)) u_linkSync (
    .clk  (clk_link),
    .rstn (rstn),
    .din  ({holdLvl, ackTgl}),
    .dout (linkSync)
  );

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      linkAckPrev   <= 1'b0;
      linkHoldClock <= 1'b0;
    end else begin
      linkAckPrev   <= linkSync[0];
      linkHoldClock <= linkSync[1];
    end
  end

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      wakeTgl     <= 1'b0;
      reqTgl      <= 1'b0;
      nackTgl     <= 1'b0;
      stopTgl     <= 1'b0;
      linkWord    <= 12'h000;
      linkTxByte  <= 8'hff;
      linkTxValid <= 1'b0;
      linkLoPhase <= 1'b0;
      linkWaiting <= 1'b0;
    end else if (linkStopRestart) begin
      stopTgl     <= ~stopTgl; // see R10 R12
      linkTxValid <= 1'b0;
      linkWaiting <= 1'b0;
    end else if (linkNack) begin
      nackTgl     <= ~nackTgl; // see R05 R10
      linkTxValid <= 1'b0;
      linkWaiting <= 1'b0;
    end else if (linkAddrRead) begin
      wakeTgl     <= ~wakeTgl; // see R13
      reqTgl      <= ~reqTgl;
      linkTxValid <= 1'b0;
      linkWaiting <= 1'b1;
    end else if (linkWaiting && (linkSync[0] ^ linkAckPrev)) begin
      linkWord    <= txWord;
      linkTxByte  <= {adcsr_pkg::LEAD_NIBBLE, txWord[11:8]}; // see R17
      linkTxValid <= 1'b1;
      linkLoPhase <= 1'b0;
      linkWaiting <= 1'b0;
    end else if (linkTxValid && linkByteTaken) begin
      if (!linkLoPhase) begin
        linkTxByte  <= linkWord[7:0]; // see R17
        linkLoPhase <= 1'b1;
      end else begin
        linkTxValid <= 1'b0;
        reqTgl      <= ~reqTgl;
        linkWaiting <= 1'b1;
      end
    end
  end

endmodule

//--- hdl/adcsr_pkg.sv
// Operation
// R01: Scan code 00 converts inputs from the first up to the chosen one.
// R02: Scan code 01 with internal clock converts the chosen input eight times.
// R03: Master never writes the reserved scan code 10; the testbench writes it in one run on purpose.
// R04: Scan code 11 with internal clock converts the chosen input once.
// R05: External clock: codes 01 and 11 convert continuously until not-acknowledge.
// R06: Reference field picks supply, external pin or internal; low bits drive/keep.
// R07: Internal reference, once up, stays on until reference setting changes.
// R08: Power-up defaults: single-ended, unipolar, first input, internal clock, supply ref.
// R09: Idle between conversions powers analog down; internal reference keeps its state.
// R10: External clock: master ends with STOP, not-acknowledge or repeated START.
// R11: Internal clock: power down once all results are in memory.
// R12: Internal-clock results stay readable until next STOP or repeated START.
// R13: Idle device wakes on a valid address byte.
// R14: Master powers internal reference 10 ms before converting, or keeps it on.
// R15: Results are straight binary unipolar, two's complement bipolar.
// R16: Clock mode bit clear uses internal oscillator, set uses serial clock.
// R17: Each result is two bytes: four high bits, then MSB to LSB.
// R18: Reserved scan code acts as a single conversion of the chosen input.
package adcsr_pkg;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SCAN_UP     = 2'h0;
  localparam logic [1:0] SCAN_REPEAT = 2'h1;
  localparam logic [1:0] SCAN_RSVD   = 2'h2;
  localparam logic [1:0] SCAN_SINGLE = 2'h3;

  localparam logic [1:0] REF_SRC_SUPPLY   = 2'h0;
  localparam logic [1:0] REF_SRC_EXTERNAL = 2'h1;
  localparam logic [1:0] REF_SRC_INTERNAL = 2'h2;

  // ----------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------
  localparam int         RESULT_W     = 12;
  localparam int         FIFO_DEPTH   = 4;
  localparam int         MEM_DEPTH    = 8;
  localparam logic [3:0] REPEAT_COUNT = 4'h8;
  localparam logic [3:0] ONE_COUNT    = 4'h1;
  localparam logic [3:0] TWO_COUNT    = 4'h2;
  localparam logic [3:0] LEAD_NIBBLE  = 4'hf;
  localparam int         REF_WAKE_MS  = 10;

  // ----------------------------------------------------------------
  // Reset values of the configuration
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_SCAN    = 2'h0;
  localparam logic       RST_CHAN    = 1'h0;
  localparam logic       RST_SINGLE  = 1'h1;
  localparam logic       RST_BIPOLAR = 1'h0;
  localparam logic       RST_EXTCLK  = 1'h0;
  localparam logic [2:0] RST_REFSEL  = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] scan;
    logic       chan;
    logic       single;
    logic       bipolar;
    logic       extClk;
    logic [2:0] refSel;
  } adcsr_cfg_t;

  localparam adcsr_cfg_t RST_CFG = '{RST_SCAN, RST_CHAN, RST_SINGLE,
                                     RST_BIPOLAR, RST_EXTCLK, RST_REFSEL};

  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_WAIT,
    S_FLUSH,
    S_HOLD
  } adcsr_state_t;

endpackage

//--- hdl/adcsr_sync.sv
`timescale 1ns/1ps
module adcsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // Destination clock
  input  wire logic         rstn,   // Async reset, active low
  input  wire logic [W-1:0] din,    // Foreign-domain levels
  output logic      [W-1:0] dout    // Synchronised levels
);

  logic [W-1:0] stage1;

  // Stage one feeds only stage two
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

//--- hdl/adcsr_fifo.sv
`timescale 1ns/1ps
module adcsr_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rstn,      // Async reset, active low
  input  wire logic         flush,     // Empties the buffer
  input  wire logic         inValid,   // Write request
  output logic              inReady,   // Space available
  input  wire logic [W-1:0] inData,    // Write word
  output logic              outValid,  // Word available
  input  wire logic         outReady,  // Read acknowledge
  output logic      [W-1:0] outData    // Head word
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wrPtr;
  logic [AW:0]  rdPtr;
  logic [AW:0]  fill;

  assign fill     = wrPtr - rdPtr;
  assign inReady  = fill != (AW+1)'(DEPTH);
  assign outValid = fill != '0;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (inValid && inReady) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outValid && outReady) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (inValid && inReady) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

endmodule

//--- verification/adcsr_ctrl_checker.sv
`timescale 1ns/1ps
module adcsr_ctrl_checker (
  input wire logic       clk_sys,        // Clock
  input wire logic       rstn,           // Reset
  input wire logic       sourceChoiceHi, // Ref bit 2
  input wire logic       pinDriveChoice, // Ref bit 1
  input wire logic       keepOnChoice,   // Ref bit 0
  input wire logic       convStart,      // Start
  input wire logic       analogPowerOn,  // Analog on
  input wire logic       refPowerOn,     // Ref on
  input wire logic [1:0] refSource,      // Ref source
  input wire logic       seqBusy,        // Busy
  input wire logic       resultsHeld     // Held
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [2:0] rs;
  assign rs = {sourceChoiceHi, pinDriveChoice, keepOnChoice};
  // Three calm samples cover both register stages
  sequence s_calm; !seqBusy && $stable(rs); endsequence
  property p_on; convStart |-> ##[0:1] analogPowerOn; endproperty
  a_on: assert property (p_on) else $error("analog off in conversion");
  property p_idle; !seqBusy [*3] |-> !analogPowerOn; endproperty
  a_idle: assert property (p_idle) else $error("analog on while idle");
  property p_done; $rose(resultsHeld) |-> ##[0:1] !analogPowerOn; endproperty
  a_done: assert property (p_done) else $error("analog on after results");
  property p_held; resultsHeld |-> !convStart; endproperty
  a_held: assert property (p_held) else $error("conversion over held results");
  property p_src; s_calm [*3] |-> refSource == (rs[2] ? 2'h2 : {1'b0, rs[1]}); endproperty
  a_src: assert property (p_src) else $error("wrong reference source");
  property p_keep; s_calm [*3] ##0 rs[2] && rs[0] |-> refPowerOn; endproperty
  a_keep: assert property (p_keep) else $error("reference not kept on");
  property p_off; s_calm [*3] ##0 !rs[2] |-> !refPowerOn; endproperty
  a_off: assert property (p_off) else $error("reference on when unused");
  property p_stay; $stable(rs) [*3] ##0 refPowerOn |=> refPowerOn; endproperty
  a_stay: assert property (p_stay) else $error("reference dropped");
endmodule
bind adcsr_ctrl adcsr_ctrl_checker CHK (.*);

//--- verification/adcsr_master.sv
`timescale 1ns/1ps
module adcsr_master (
  input  wire logic [7:0] txByte,  // Byte from device
  input  wire logic       txValid, // Byte ready
  output logic            clkLink, // Serial clock
  output logic [3:0]      ev       // Stop, nack, taken, address
);
  logic run = 1'b0;
  initial ev = 4'h0;
  // Parks low between frames; odd start keeps edges off the system clock's
  initial begin
    clkLink = 1'b0;
    #1.3;
    forever #62.5 if (run || clkLink) clkLink = ~clkLink;
  end
  task automatic send(input int k);
    @(negedge clkLink) ev <= 4'h1 << k;
    @(negedge clkLink) ev <= 4'h0;
  endtask
  task automatic get_word(output logic [15:0] w, output bit ok);
    int n;
    ok = 1'b1;
    for (int b = 0; b < 2; b++) begin
      for (n = 0; txValid !== 1'b1 && n < 800; n++) #125;
      ok &= n < 800;
      @(negedge clkLink) w = {w[7:0], txByte};
      send(1);
    end
  endtask
endmodule

//--- verification/adc_scan_ref_shutdown_ctrl_tb.sv
`timescale 1ns/1ps
module adc_scan_ref_shutdown_ctrl_tb;
  logic                  clk_sys  = 1'b0;
  logic                  rstn     = 1'b1;
  logic                  convDone = 1'b0;
  logic [11:0]           convRaw  = 12'h000;
  logic [31:0]           lfsr     = 32'hc805;
  adcsr_pkg::adcsr_cfg_t cfg      = adcsr_pkg::RST_CFG;
  logic                  convStart, convChannel, convDiff, analogPowerOn;
  logic                  refPowerOn, seqBusy, resultsHeld, txValid, clkLink, convExtClock, refPinDrive;
  logic [1:0]            refSource;
  logic [7:0]            txByte;
  logic [3:0]            ev;
  logic [11:0]           raws[$];
  logic                  chans[$];
  int                    mismatches = 0;
  int                    testsRun = 0;
  always #2.5 clk_sys = ~clk_sys;
  adcsr_master M (.txByte(txByte), .txValid(txValid), .clkLink(clkLink), .ev(ev));
  adcsr_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clkLink), .scanSelectHi(cfg.scan[1]),
    .scanSelectLo(cfg.scan[0]), .channelChoiceBit(cfg.chan), .singleEndedSelect(cfg.single),
    .bipolarSelect(cfg.bipolar), .clockModeExt(cfg.extClk), .sourceChoiceHi(cfg.refSel[2]),
    .pinDriveChoice(cfg.refSel[1]), .keepOnChoice(cfg.refSel[0]), .convStart(convStart),
    .convChannel(convChannel), .convDiff(convDiff), .convExtClock(convExtClock), .convDone(convDone),
    .convRaw(convRaw), .analogPowerOn(analogPowerOn), .refPowerOn(refPowerOn), .refPinDrive(refPinDrive),
    .refSource(refSource), .seqBusy(seqBusy), .resultsHeld(resultsHeld), .linkAddrRead(ev[0]), .linkByteTaken(ev[1]),
    .linkNack(ev[2]), .linkStopRestart(ev[3]), .linkTxByte(txByte), .linkTxValid(txValid), .linkHoldClock());
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Converter model with random latency and codes
  always begin
    @(posedge clk_sys);
    if (convStart === 1'b1) begin
      chans.push_back(convChannel);
      repeat (2 + lfsr[1:0]) @(posedge clk_sys);
      convRaw  <= lfsr[11:0];
      convDone <= 1'b1;
      raws.push_back(lfsr[11:0]);
      lfsr = nxt(lfsr);
      @(posedge clk_sys) convDone <= 1'b0;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run(input logic [1:0] sc, input logic ch, bp, ex, input int nconv, nread);
    logic [15:0] w;
    logic [11:0] e;
    bit          ok;
    int          n;
    @(posedge clk_sys) cfg <= '{sc, ch, 1'b1, bp, ex, cfg.refSel};
    raws = {};
    chans = {};
    repeat (4) @(posedge clk_sys);
    M.run = 1'b1;
    M.send(0);
    for (int i = 0; i < nread; i++) begin
      M.get_word(w, ok);
      if (!ok) begin
        mismatches++;
        report_and_stop();
      end
      e = raws[ex ? i : i % nconv];
      check(w, {4'hf, e ^ {bp, 11'h000}}, "word");
      if (ex) #2000;
    end
    if (!ex) check(16'(resultsHeld), 16'h1, "held");
    M.send(ex ? 2 : 3);
    for (n = 0; {seqBusy, analogPowerOn, resultsHeld} !== 3'h0 && n < 4000; n++) @(negedge clk_sys);
    check(16'(n < 4000), 16'h1, "idle");
    if (n == 4000) report_and_stop();
    check(16'(convExtClock), 16'(ex), "clkmode");
    M.run = 1'b0;
    if (!ex) check(16'(chans.size()), 16'(nconv), "count");
    check(16'({chans[0], chans[$]}), 16'({sc != 2'h0 && ch, ch}), "chan");
    $display("test scan %h ext %h done", sc, ex);
  endtask
  initial begin
    // Falling edge at time zero resets the link side before its clock runs
    rstn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check(16'({analogPowerOn, refPowerOn, convStart, convDiff, refSource}), 16'h0, "reset");
    rstn <= 1'b1;
    run(2'h0, 1'b0, 1'b0, 1'b0, 1, 2);
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_sys) cfg.refSel <= r[2:0];
      repeat (5) @(posedge clk_sys);
      check(16'({refSource, refPowerOn}), 16'({r[2] ? 2'h2 : {1'b0, r[1]}, r[2] & r[0]}), "ref");
      check(16'(refPinDrive), 16'h0, "pindrive");
    end
    @(posedge clk_sys) cfg.refSel <= 3'h5;
    run(2'h0, 1'b1, 1'b1, 1'b0, 2, 3);
    check(16'(refPowerOn), 16'h1, "refkeep");
    run(2'h1, 1'b1, 1'b0, 1'b0, 8, 9);
    run(2'h3, 1'b0, 1'b1, 1'b0, 1, 2);
    run(2'h2, 1'b1, 1'b0, 1'b0, 1, 1); // broken on purpose only here
    run(2'h1, 1'b0, 1'b1, 1'b1, 1, 6);
    run(2'h3, 1'b1, 1'b0, 1'b1, 1, 6);
    report_and_stop();
  end
endmodule
